// [src/sup_pkg.sv]
// Constants, reset values and carrier types for the two-level fault supervisor
//
// Contract
// - Oil level low starts both stage timers
// - Oil level alarm action resets to none
// - Sensor not installed: no flags raised
// - Coolant flow low raises warning, alarm flags
// - Coolant flow resets 60 s, 180 s, none
// - Coolant over-temperature raises both flags; none
// - Booster motor over-temperature raises both flags
// - Booster motor resets 30 s, 60 s, stop
// - Booster oil over-temperature raises both flags
// - Booster oil resets 30 s, 60 s, none
// - Barrier gas low raises both flags
// - Barrier gas alarm action resets to none
// - Vibration thresholds, one shared delay, two stages
// - Vibration alarm action resets to emergency_off
// - Vessel pressure: two thresholds, delays, action
// - Vessel resets 5 s, 10 s, emergency_off
package sup_pkg;
    localparam int SUP_NCH = 8;
    localparam int SUP_DW = 16;
    localparam int SUP_AW = 12;
    // Channel indices
    localparam int SUP_CH_OIL_LEVEL = 0;
    localparam int SUP_CH_COOL_FLOW = 1;
    localparam int SUP_CH_COOL_TEMP = 2;
    localparam int SUP_CH_MOTOR_TEMP = 3;
    localparam int SUP_CH_OIL_TEMP = 4;
    localparam int SUP_CH_BARRIER = 5;
    localparam int SUP_CH_VIBRATION = 6;
    localparam int SUP_CH_VESSEL = 7;
    localparam int SUP_NDIG = 6;
    // Timing
    localparam longint SUP_CLK_HZ = 25000000;
    localparam int SUP_TICK_S = 1;
    localparam int SUP_SEC_CYCLES = int'(SUP_CLK_HZ * SUP_TICK_S);
    // Alarm actions
    typedef enum logic [1:0] {
        SUP_ACT_NONE = 2'h0,
        SUP_ACT_STOP_BOOSTER = 2'h1,
        SUP_ACT_EMERGENCY_OFF = 2'h3
    } sup_action_t;
    // Register byte offsets
    localparam logic [7:0] SUP_OFS_DELAY0 = 8'h00;
    localparam logic [7:0] SUP_OFS_CTRL0 = 8'h04;
    localparam int SUP_CH_STRIDE = 8;
    localparam logic [7:0] SUP_OFS_VIB_LVL = 8'h40;
    localparam logic [7:0] SUP_OFS_VES_LVL = 8'h44;
    localparam logic [7:0] SUP_OFS_STATUS = 8'h48;
    localparam logic [7:0] SUP_OFS_COND = 8'h4c;
    // Field positions
    localparam int SUP_F_WARN_LSB = 0;
    localparam int SUP_F_ALARM_LSB = 16;
    localparam int SUP_F_INST = 0;
    localparam int SUP_F_ACT_LSB = 1;
    localparam int SUP_F_STOP = 16;
    localparam int SUP_F_EMO = 17;
    // Reset values (delays in seconds)
    localparam logic [SUP_DW-1:0] SUP_WARN_RST [SUP_NCH] = '{
        16'h001e,
        16'h003c,
        16'h001e,
        16'h001e,
        16'h001e,
        16'h001e,
        16'h001e,
        16'h0005
    };
    localparam logic [SUP_DW-1:0] SUP_ALARM_RST [SUP_NCH] = '{
        16'h003c,
        16'h00b4,
        16'h003c,
        16'h003c,
        16'h003c,
        16'h003c,
        16'h003c,
        16'h000a
    };
    localparam sup_action_t SUP_ACT_RST [SUP_NCH] = '{
        SUP_ACT_NONE,
        SUP_ACT_NONE,
        SUP_ACT_NONE,
        SUP_ACT_STOP_BOOSTER,
        SUP_ACT_NONE,
        SUP_ACT_NONE,
        SUP_ACT_EMERGENCY_OFF,
        SUP_ACT_EMERGENCY_OFF
    };
    localparam logic SUP_INST_RST = 1'b1;
    localparam logic [SUP_AW-1:0] SUP_VIB_WARN_RST = 12'h400;
    localparam logic [SUP_AW-1:0] SUP_VIB_ALARM_RST = 12'h800;
    localparam logic [SUP_AW-1:0] SUP_VES_WARN_RST = 12'h400;
    localparam logic [SUP_AW-1:0] SUP_VES_ALARM_RST = 12'h800;
    // Flag carrier
    typedef struct packed {
        logic [SUP_NCH-1:0] alarm;
        logic [SUP_NCH-1:0] warn;
    } sup_flags_t;
endpackage

// [src/sup_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module sup_sync #(
    parameter int WIDTH = 6
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_pin,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_level <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    o_level[i] <= s3[i];
                end
            end
        end
    end
endmodule

// [src/sup_stage.sv]
// One supervision stage: seconds delay timer and its flag
`timescale 1ns/10ps
module sup_stage (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_tick,
    input wire logic i_cond,
    input wire logic i_enable,
    input wire logic [sup_pkg::SUP_DW-1:0] i_delay,
    output logic o_flag
);
    logic [sup_pkg::SUP_DW-1:0] secs;
    logic active;
    logic expired;

    assign active = i_cond && i_enable;
    assign expired = secs >= i_delay;

    // Saturates at the programmed delay so a long fault never wraps
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            secs <= '0;
        end else if (!active) begin
            secs <= '0;
        end else if (i_tick && !expired) begin
            secs <= secs + 16'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_flag <= 1'b0;
        end else begin
            o_flag <= active && expired;
        end
    end
endmodule

// [src/sup_top.sv]
// Two-level fault supervisor: channel stages, seconds tick and Avalon-MM registers
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
module sup_top #(
    parameter int SEC_CYCLES = sup_pkg::SUP_SEC_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    // Avalon-MM slave
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Sensors
    input wire logic [sup_pkg::SUP_NDIG-1:0] i_fault,
    input wire logic [sup_pkg::SUP_AW-1:0] i_vibration,
    input wire logic [sup_pkg::SUP_AW-1:0] i_vessel_pressure,
    // Handpad and actions
    output logic [sup_pkg::SUP_NCH-1:0] o_warn,
    output logic [sup_pkg::SUP_NCH-1:0] o_alarm,
    output logic o_stop_booster,
    output logic o_emergency_off
);
    localparam int TW = $clog2(SEC_CYCLES + 1);
    localparam int NCH = sup_pkg::SUP_NCH;
    localparam int NDIG = sup_pkg::SUP_NDIG;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [sup_pkg::SUP_DW-1:0] field16(input logic [31:0] v, input int lsb);
        return v[lsb +: sup_pkg::SUP_DW];
    endfunction

    // ------------------------------------------------------------
    // Seconds tick
    // ------------------------------------------------------------
    logic [TW-1:0] tick_cnt;
    logic tick;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == TW'(SEC_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + TW'(1);
            tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [31:0] delay_reg [NCH];
    logic [NCH-1:0] installed;
    sup_pkg::sup_action_t action [NCH];
    logic [sup_pkg::SUP_AW-1:0] vib_warn_lvl;
    logic [sup_pkg::SUP_AW-1:0] vib_alarm_lvl;
    logic [sup_pkg::SUP_AW-1:0] ves_warn_lvl;
    logic [sup_pkg::SUP_AW-1:0] ves_alarm_lvl;
    logic bus_take;
    logic [31:0] wr_merged;

    // Access completes on the edge where waitrequest is seen low
    assign bus_take = (i_read || i_write) && !o_waitrequest;

    always_comb begin
        wr_merged = 32'h0000_0000;
        for (int c = 0; c < NCH; c++) begin
            if (i_address == sup_pkg::SUP_OFS_DELAY0 + 8'(c * sup_pkg::SUP_CH_STRIDE)) begin
                wr_merged = merge_be(delay_reg[c], i_writedata, i_byteenable);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int c = 0; c < NCH; c++) begin
                delay_reg[c] <= {sup_pkg::SUP_ALARM_RST[c], sup_pkg::SUP_WARN_RST[c]};
            end
        end else if (bus_take && i_write) begin
            for (int c = 0; c < NCH; c++) begin
                if (i_address == sup_pkg::SUP_OFS_DELAY0 + 8'(c * sup_pkg::SUP_CH_STRIDE)) begin
                    delay_reg[c] <= wr_merged;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            for (int c = 0; c < NCH; c++) begin
                installed[c] <= sup_pkg::SUP_INST_RST;
                action[c] <= sup_pkg::SUP_ACT_RST[c];
            end
        end else if (bus_take && i_write && i_byteenable[0]) begin
            for (int c = 0; c < NCH; c++) begin
                if (i_address == sup_pkg::SUP_OFS_CTRL0 + 8'(c * sup_pkg::SUP_CH_STRIDE)) begin
                    installed[c] <= i_writedata[sup_pkg::SUP_F_INST];
                    action[c] <= sup_pkg::sup_action_t'(i_writedata[sup_pkg::SUP_F_ACT_LSB +: 2]);
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            vib_warn_lvl <= sup_pkg::SUP_VIB_WARN_RST;
            vib_alarm_lvl <= sup_pkg::SUP_VIB_ALARM_RST;
            ves_warn_lvl <= sup_pkg::SUP_VES_WARN_RST;
            ves_alarm_lvl <= sup_pkg::SUP_VES_ALARM_RST;
        end else if (bus_take && i_write) begin
            if (i_address == sup_pkg::SUP_OFS_VIB_LVL) begin
                vib_warn_lvl <= i_writedata[sup_pkg::SUP_F_WARN_LSB +: sup_pkg::SUP_AW];
                vib_alarm_lvl <= i_writedata[sup_pkg::SUP_F_ALARM_LSB +: sup_pkg::SUP_AW];
            end
            if (i_address == sup_pkg::SUP_OFS_VES_LVL) begin
                ves_warn_lvl <= i_writedata[sup_pkg::SUP_F_WARN_LSB +: sup_pkg::SUP_AW];
                ves_alarm_lvl <= i_writedata[sup_pkg::SUP_F_ALARM_LSB +: sup_pkg::SUP_AW];
            end
        end
    end

    // ------------------------------------------------------------
    // Fault conditions
    // ------------------------------------------------------------
    logic [NDIG-1:0] fault_level;
    logic [NCH-1:0] cond_warn;
    logic [NCH-1:0] cond_alarm;
    logic [sup_pkg::SUP_DW-1:0] warn_delay [NCH];
    logic [sup_pkg::SUP_DW-1:0] alarm_delay [NCH];

    sup_sync #(
        .WIDTH(NDIG)
    ) u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_pin(i_fault),
        .o_level(fault_level)
    );

    // Digital channels feed both stages from one indication
    always_comb begin
        cond_warn = '0;
        cond_alarm = '0;
        cond_warn[NDIG-1:0] = fault_level;
        cond_alarm[NDIG-1:0] = fault_level;
        cond_warn[sup_pkg::SUP_CH_VIBRATION] = i_vibration > vib_warn_lvl;
        cond_alarm[sup_pkg::SUP_CH_VIBRATION] = i_vibration > vib_alarm_lvl;
        cond_warn[sup_pkg::SUP_CH_VESSEL] = i_vessel_pressure > ves_warn_lvl;
        cond_alarm[sup_pkg::SUP_CH_VESSEL] = i_vessel_pressure > ves_alarm_lvl;
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            warn_delay[c] = field16(delay_reg[c], sup_pkg::SUP_F_WARN_LSB);
            alarm_delay[c] = field16(delay_reg[c], sup_pkg::SUP_F_ALARM_LSB);
        end
        // Vibration stages share the one delay value
        alarm_delay[sup_pkg::SUP_CH_VIBRATION] = warn_delay[sup_pkg::SUP_CH_VIBRATION];
    end

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    sup_pkg::sup_flags_t flags;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        sup_stage u_warn (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_tick(tick),
            .i_cond(cond_warn[g]),
            .i_enable(installed[g]),
            .i_delay(warn_delay[g]),
            .o_flag(flags.warn[g])
        );
        sup_stage u_alarm (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_tick(tick),
            .i_cond(cond_alarm[g]),
            .i_enable(installed[g]),
            .i_delay(alarm_delay[g]),
            .o_flag(flags.alarm[g])
        );
    end

    // ------------------------------------------------------------
    // Flags and actions
    // ------------------------------------------------------------
    logic next_stop;
    logic next_emo;

    // Not-installed channels have no alarm, so their action is never applied
    always_comb begin
        next_stop = 1'b0;
        next_emo = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            if (flags.alarm[c] && installed[c]) begin
                next_stop = next_stop || (action[c] == sup_pkg::SUP_ACT_STOP_BOOSTER);
                next_emo = next_emo || (action[c] == sup_pkg::SUP_ACT_EMERGENCY_OFF);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_warn <= '0;
            o_alarm <= '0;
            o_stop_booster <= 1'b0;
            o_emergency_off <= 1'b0;
        end else begin
            o_warn <= flags.warn;
            o_alarm <= flags.alarm;
            o_stop_booster <= next_stop;
            o_emergency_off <= next_emo;
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM handshake and read data
    // ------------------------------------------------------------
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int c = 0; c < NCH; c++) begin
            if (i_address == sup_pkg::SUP_OFS_DELAY0 + 8'(c * sup_pkg::SUP_CH_STRIDE)) begin
                next_rdata = delay_reg[c];
            end
            if (i_address == sup_pkg::SUP_OFS_CTRL0 + 8'(c * sup_pkg::SUP_CH_STRIDE)) begin
                next_rdata[sup_pkg::SUP_F_INST] = installed[c];
                next_rdata[sup_pkg::SUP_F_ACT_LSB +: 2] = action[c];
            end
        end
        case (i_address)
            sup_pkg::SUP_OFS_VIB_LVL: begin
                next_rdata[sup_pkg::SUP_F_WARN_LSB +: sup_pkg::SUP_AW] = vib_warn_lvl;
                next_rdata[sup_pkg::SUP_F_ALARM_LSB +: sup_pkg::SUP_AW] = vib_alarm_lvl;
            end
            sup_pkg::SUP_OFS_VES_LVL: begin
                next_rdata[sup_pkg::SUP_F_WARN_LSB +: sup_pkg::SUP_AW] = ves_warn_lvl;
                next_rdata[sup_pkg::SUP_F_ALARM_LSB +: sup_pkg::SUP_AW] = ves_alarm_lvl;
            end
            sup_pkg::SUP_OFS_STATUS: begin
                next_rdata[15:0] = {o_alarm, o_warn};
                next_rdata[sup_pkg::SUP_F_STOP] = o_stop_booster;
                next_rdata[sup_pkg::SUP_F_EMO] = o_emergency_off;
            end
            sup_pkg::SUP_OFS_COND: begin
                next_rdata[15:0] = {cond_alarm, cond_warn};
            end
            default: begin
            end
        endcase
    end

    // One wait cycle per access; unmapped reads return zero
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
        end else if (bus_take) begin
            o_waitrequest <= 1'b1;
        end else if (i_read || i_write) begin
            o_waitrequest <= 1'b0;
            o_readdata <= i_read ? next_rdata : o_readdata;
        end
    end
endmodule

// [sim/sup_chk.sv]
// Port-level assertions for the fault supervisor
`timescale 1ns/10ps
module sup_chk #(
    parameter int SEC_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic [sup_pkg::SUP_NDIG-1:0] i_fault,
    input wire logic [sup_pkg::SUP_AW-1:0] i_vibration,
    input wire logic [sup_pkg::SUP_AW-1:0] i_vessel_pressure,
    input wire logic [sup_pkg::SUP_NCH-1:0] o_warn,
    input wire logic [sup_pkg::SUP_NCH-1:0] o_alarm,
    input wire logic o_stop_booster,
    input wire logic o_emergency_off
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    wait_one_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("waitrequest not low after one wait cycle");
    wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low longer than one cycle");
    wait_idle_a: assert property (!(i_read || i_write) |=> o_waitrequest)
        else $error("waitrequest low without request");
    // ----------------------------------------
    // Flags and actions
    // ----------------------------------------
    // Pin must have been high three cycles before any rise; a one-cycle pin pulse never reaches the stages
    fault_rise_a: assert property ((o_warn[5:0] & ~$past(o_warn[5:0]) & ~$past(i_fault, 3)) == 6'h0)
        else $error("warning rose without fault");
    alarm_rise_a: assert property ((o_alarm[5:0] & ~$past(o_alarm[5:0]) & ~$past(i_fault, 3)) == 6'h0)
        else $error("alarm rose without fault");
    flag_drop_a: assert property ((i_fault == 6'h00)[*8] |-> (o_warn[5:0] == 6'h00) && (o_alarm[5:0] == 6'h00))
        else $error("flag held after fault gone");
    vib_quiet_a: assert property ((i_vibration == 12'h000)[*4] |-> !o_warn[6] && !o_alarm[6])
        else $error("vibration flag without vibration");
    ves_quiet_a: assert property ((i_vessel_pressure == 12'h000)[*4] |-> !o_warn[7] && !o_alarm[7])
        else $error("vessel flag without pressure");
    stop_src_a: assert property (o_stop_booster |-> (o_alarm != 8'h00) || ($past(o_alarm) != 8'h00))
        else $error("booster stop without alarm");
    emo_src_a: assert property (o_emergency_off |-> (o_alarm != 8'h00) || ($past(o_alarm) != 8'h00))
        else $error("emergency off without alarm");
    cover property ($rose(o_alarm[1]));
    cover property ($rose(o_stop_booster));
    cover property ($rose(o_emergency_off));
endmodule

// [sim/sup_sensor_model.sv]
// Pump sensor model: fault levels and analog readings
`timescale 1ns/10ps
module sup_sensor_model (
    input wire logic i_clk,
    output logic [5:0] o_fault,
    output logic [11:0] o_vibration,
    output logic [11:0] o_vessel_pressure
);
    // Sensors are levels that hold; callers act just after a rising edge
    initial begin
        o_fault = 6'h00;
        o_vibration = 12'h000;
        o_vessel_pressure = 12'h000;
    end
    task automatic set_fault(input int b, input logic v);
        o_fault[b] <= v;
    endtask
    task automatic set_ana(input int ch, input logic [11:0] v);
        if (ch == 0) begin
            o_vibration <= v;
        end else begin
            o_vessel_pressure <= v;
        end
    endtask
endmodule

// [sim/tb_sup_top.sv]
// Self-checking bench for the fault supervisor
`timescale 1ns/10ps
module tb_sup_top;
    localparam int SEC = 4;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic [5:0] i_fault;
    logic [11:0] i_vibration;
    logic [11:0] i_vessel_pressure;
    logic [7:0] o_warn;
    logic [7:0] o_alarm;
    logic o_stop_booster;
    logic o_emergency_off;
    logic [31:0] rd;
    logic seen;
    int n_errors = 0;
    int checked = 0;
    int wd[8] = '{30, 60, 30, 30, 30, 30, 30, 5};
    int ad[8] = '{60, 180, 60, 60, 60, 60, 60, 10};
    logic [1:0] act[8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h3, 2'h3};

    always #20 i_clk = ~i_clk;

    sup_top #(.SEC_CYCLES(SEC)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_fault(i_fault),
        .i_vibration(i_vibration), .i_vessel_pressure(i_vessel_pressure), .o_warn(o_warn),
        .o_alarm(o_alarm), .o_stop_booster(o_stop_booster), .o_emergency_off(o_emergency_off));
    sup_sensor_model pump (.i_clk(i_clk), .o_fault(i_fault), .o_vibration(i_vibration),
        .o_vessel_pressure(i_vessel_pressure));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= ~wr;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
        @(posedge i_clk);
        chk(32'(n < 20), 32'h1, "bus answer");
    endtask
    // Times flag rises from now; jitter of one tick plus sync latency allowed
    task automatic run_stage(input int ch, input int dw, input int da, input logic stp, input logic emergency_off);
        int n;
        int tw;
        int ta;
        n = 0;
        tw = 0;
        ta = 0;
        while (ta == 0 && n < 1000) begin
            @(posedge i_clk);
            n++;
            if (tw == 0 && o_warn[ch] === 1'b1) tw = n;
            if (ta == 0 && o_alarm[ch] === 1'b1) ta = n;
        end
        chk(32'(tw >= (dw - 1) * SEC && tw <= dw * SEC + 12), 32'h1, "warn delay");
        chk(32'(ta >= (da - 1) * SEC && ta <= da * SEC + 12), 32'h1, "alarm delay");
        repeat (2) @(posedge i_clk);
        chk(32'({o_stop_booster, o_emergency_off}), 32'({stp, emergency_off}), "action");
        bus(1'b0, 8'h48, 32'h0);
        chk(rd, {14'h0, emergency_off, stp, 16'(16'h0101 << ch)}, "status");
    endtask
    task automatic watch(input int ch, input int cyc, input int per);
        seen = 1'b0;
        for (int i = 0; i < cyc; i++) begin
            if (per > 0 && i % per == 0) pump.set_fault(ch, 1'b1);
            if (per > 0 && i % per == per / 2) pump.set_fault(ch, 1'b0);
            @(posedge i_clk);
            seen |= o_warn[ch] | o_alarm[ch] | o_stop_booster | o_emergency_off;
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        chk(32'({o_warn, o_alarm, o_stop_booster, o_emergency_off}), 32'h0, "reset flags");
        for (int ch = 0; ch < 8; ch++) begin
            bus(1'b0, 8'(8 * ch), 32'h0);
            chk(rd, {16'(ad[ch]), 16'(wd[ch])}, "delay reset");
            bus(1'b0, 8'(8 * ch + 4), 32'h0);
            chk(32'(rd[2:0]), 32'({act[ch], 1'b1}), "ctrl reset");
        end
        bus(1'b1, 8'h80, 32'hffff_ffff);
        bus(1'b0, 8'h80, 32'h0);
        chk(rd, 32'h0, "unmapped");
        $display("test defaults done");
        for (int ch = 0; ch < 6; ch++) begin
            bus(1'b1, 8'(8 * ch), 32'h0004_0002);
            pump.set_fault(ch, 1'b1);
            run_stage(ch, 2, 4, 1'(ch == 3), 1'b0);
            pump.set_fault(ch, 1'b0);
            repeat (10) @(posedge i_clk);
            chk(32'({o_warn, o_alarm}), 32'h0, "flags clear");
        end
        $display("test digital channels done");
        bus(1'b1, 8'h08, 32'h0004_0003);
        watch(1, 36, 12);
        chk(32'(seen), 32'h0, "interrupted");
        bus(1'b1, 8'h1c, 32'h0000_0002);
        pump.set_fault(3, 1'b1);
        watch(3, 40, 0);
        chk(32'(seen), 32'h0, "not installed");
        pump.set_fault(3, 1'b0);
        $display("test restart and removal done");
        bus(1'b1, 8'h40, 32'h0200_0100);
        bus(1'b1, 8'h30, 32'h0002_0002);
        pump.set_ana(0, 12'h100);
        watch(6, 24, 0);
        chk(32'(seen), 32'h0, "at level");
        pump.set_ana(0, 12'h101);
        repeat (3 * SEC + 12) @(posedge i_clk);
        chk(32'({o_warn[6], o_alarm[6]}), 32'h2, "vib warn");
        pump.set_ana(0, 12'h201);
        run_stage(6, 1, 2, 1'b0, 1'b1);
        pump.set_ana(0, 12'h000);
        bus(1'b1, 8'h44, 32'h0200_0100);
        bus(1'b1, 8'h38, 32'h0003_0001);
        pump.set_ana(1, 12'h201);
        run_stage(7, 1, 3, 1'b0, 1'b1);
        pump.set_ana(1, 12'h000);
        $display("test analog channels done");
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        end_sim();
    end
endmodule

bind sup_top sup_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_fault(i_fault), .i_vibration(i_vibration), .i_vessel_pressure(i_vessel_pressure),
    .o_warn(o_warn), .o_alarm(o_alarm), .o_stop_booster(o_stop_booster), .o_emergency_off(o_emergency_off));
